// [include/cpc_pkg.sv]
// Package for the counter-array PWM cycle configuration slice.
// Holds special-function register addresses, field positions, reset values
// and the cycle-length encoding shared by the top and the channel slice.
package cpc_pkg;

   // ****************************************************************
   // Register addresses on the special-function register bus
   // ****************************************************************
   localparam logic [7:0] ADDR_PWM_CYCLE_CONFIG = 8'hDF;  // Cycle configuration.
   localparam logic [7:0] ADDR_MODE_BASE        = 8'hDA;  // Mode register of channel 0.
   localparam logic [7:0] ADDR_VALUE_LOW_BASE   = 8'hE9;  // Low value byte of channel 0.
   localparam logic [7:0] ADDR_VALUE_STRIDE     = 8'h02;  // Low/high pair per channel.

   // ****************************************************************
   // Field positions of pwm_cycle_config
   // ****************************************************************
   localparam int POS_RELOAD_REG_SELECT = 7;   // Steers value accesses to reload.
   localparam int POS_CYCLE_OVF_IRQ_EN  = 6;   // Interrupt mask of the flag.
   localparam int POS_CYCLE_OVF_FLAG    = 5;   // Sticky cycle overflow flag.
   localparam int POS_CYCLE_LEN_MSB     = 1;   // Cycle length field, high bit.
   localparam int POS_CYCLE_LEN_LSB     = 0;   // Cycle length field, low bit.

   // ****************************************************************
   // Field positions of channel_mode_config
   // ****************************************************************
   localparam int POS_WIDE_PWM_SELECT   = 7;   // 16-bit PWM select.
   localparam int POS_COMPARATOR_ENABLE = 6;   // Comparator function enable.
   localparam int POS_PULSE_MOD_ENABLE  = 1;   // PWM function enable.

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0]  RST_PWM_CYCLE_CONFIG = 8'h00;  // All fields clear.
   localparam logic [7:0]  RST_MODE_CONFIG      = 8'h00;  // Channel idle.
   localparam logic [15:0] RST_CHANNEL_VALUE    = 16'h0000; // Compare and reload.
   localparam logic [7:0]  RST_READ_DATA        = 8'h00;  // Idle read bus.

   // ****************************************************************
   // Cycle length encoding
   // ****************************************************************
   typedef enum logic [1:0] {
      CPC_LEN_8  = 2'b00,  // 8-bit cycle.
      CPC_LEN_9  = 2'b01,  // 9-bit cycle.
      CPC_LEN_10 = 2'b10,  // 10-bit cycle.
      CPC_LEN_11 = 2'b11   // 11-bit cycle.
   } cpc_len_t;

   // Mask of the counter bits that form one PWM cycle of the given length.
   function automatic logic [15:0] cpc_len_mask(input cpc_len_t len);
      logic [15:0] m;
      m = 16'h00FF;
      case (len)
         CPC_LEN_8:  m = 16'h00FF;
         CPC_LEN_9:  m = 16'h01FF;
         CPC_LEN_10: m = 16'h03FF;
         CPC_LEN_11: m = 16'h07FF;
         default:    m = 16'h00FF;
      endcase
      return m;
   endfunction : cpc_len_mask

endpackage : cpc_pkg

// [core/cpc_channel.sv]
// One capture/compare channel slice: mode register, compare value, hidden
// reload value and the PWM comparison for 8 to 11-bit and 16-bit cycles.
// Assumes the top decodes the bus and hands it clean one-cycle strobes.
`timescale 1ns/1ps

module cpc_channel
   import cpc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              mode_wr,
   input  wire logic              value_low_wr,
   input  wire logic              value_high_wr,
   input  wire logic [7:0]        wdata,
   input  wire logic              sel_reload,
   input  wire cpc_pkg::cpc_len_t cycle_len,
   input  wire logic              cycle_ovf,
   input  wire logic [15:0]       main_counter,
   output logic [7:0]             mode_reg,
   output logic [15:0]            compare_reg,
   output logic [15:0]            reload_reg,
   output logic                   wide_pwm_select,
   output logic                   pwm_out
);
   import cpc_pkg::*;

   // ****************************************************************
   // Decoded mode bits
   // ****************************************************************
   logic        pwm_active;   // Channel runs as a PWM generator.
   logic        short_pwm;    // PWM with 8 to 11-bit cycle.
   logic [15:0] len_mask;     // Counter bits that form one cycle.
   logic        pwm_next;     // Next value of the PWM output.

   assign wide_pwm_select = mode_reg[POS_WIDE_PWM_SELECT];
   assign pwm_active = mode_reg[POS_COMPARATOR_ENABLE] & mode_reg[POS_PULSE_MOD_ENABLE];
   assign short_pwm  = pwm_active & ~wide_pwm_select;
   // ignore cycle length: a wide channel compares all sixteen bits.
   assign len_mask   = wide_pwm_select ? 16'hFFFF : cpc_len_mask(cycle_len);

   // Mode register, written straight from the bus.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode_reg <= RST_MODE_CONFIG;
      end else if (mode_wr) begin
         mode_reg <= wdata;
      end
   end

   // Reload value; only reachable while the select bit steers accesses here.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reload_reg <= RST_CHANNEL_VALUE;
      end else begin
         if (sel_reload && value_low_wr) begin
            reload_reg[7:0] <= wdata;
         end
         if (sel_reload && value_high_wr) begin
            reload_reg[15:8] <= wdata;
         end
      end
   end

   // Compare value. A bus write wins over the cycle-boundary copy so that
   // software never loses a byte it has just written.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         compare_reg <= RST_CHANNEL_VALUE;
      end else begin
         // reload at boundary; other modes skip it; copy on overflow.
         if (cycle_ovf && short_pwm) begin
            compare_reg <= reload_reg;
         end
         if (!sel_reload && value_low_wr) begin
            compare_reg[7:0] <= wdata;
         end
         if (!sel_reload && value_high_wr) begin
            compare_reg[15:8] <= wdata;
         end
      end
   end

   // shared cycle length: the comparison uses only the cycle bits.
   always_comb begin
      pwm_next = 1'b0;
      if (pwm_active) begin
         pwm_next = (main_counter & len_mask) < (compare_reg & len_mask);
      end
   end

   // Registered PWM output so the pin never sees comparator glitches.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= pwm_next;
      end
   end

endmodule : cpc_channel

// [core/cpc_top.sv]
// Top of the counter-array PWM cycle configuration slice: cycle
// configuration register, overflow detection, channel value steering and
// the read-back path of the special-function register bus.
// Assumes the counter timebase runs on clk and presents its count each cycle.
`timescale 1ns/1ps

module cpc_top
   import cpc_pkg::*;
#(
   parameter int NUM_CHANNELS = 3  // Capture/compare channels served.
)
(
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic [7:0]                sfr_addr,
   input  wire logic                      sfr_wr,
   input  wire logic                      sfr_rd,
   input  wire logic [7:0]                sfr_wdata,
   output logic [7:0]                     sfr_rdata,
   output logic                           sfr_rdata_valid,
   input  wire logic [15:0]               array_main_counter,
   output logic                           counter_array_irq_req,
   output logic                           cycle_ovf_pulse,
   output logic [NUM_CHANNELS-1:0]        wide_pwm_select,
   output logic [NUM_CHANNELS-1:0]        pwm_out,
   output logic [NUM_CHANNELS*16-1:0]     channel_compare_value
);
   import cpc_pkg::*;

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // The address map packs low/high value pairs; from a sixth channel on
   // the mode registers would run into the cycle configuration address.
   if (NUM_CHANNELS < 1 || NUM_CHANNELS > 3) begin : g_bad_channels
      $error("cpc_top: NUM_CHANNELS must be 1 to 3");
   end

   // ****************************************************************
   // Configuration register fields
   // ****************************************************************
   logic     reload_reg_select_reg;     // Steers value accesses.
   logic     cycle_ovf_irq_enable_reg;  // Interrupt mask.
   logic     cycle_ovf_flag_reg;        // Sticky overflow flag.
   cpc_len_t cycle_length_field_reg;    // Cycle length code.
   logic     cfg_wr;                    // Write strobe of the config register.

   // ****************************************************************
   // Overflow detection
   // ****************************************************************
   logic [15:0] counter_prev_reg;       // Counter value one cycle earlier.
   logic [15:0] cycle_mask;             // Bits forming one cycle.
   logic        cycle_ovf;              // Overflow of the selected bit.

   // ****************************************************************
   // Per-channel strobes and read-back
   // ****************************************************************
   logic [NUM_CHANNELS-1:0] mode_wr;     // Mode register write.
   logic [NUM_CHANNELS-1:0] low_wr;      // Low value byte write.
   logic [NUM_CHANNELS-1:0] high_wr;     // High value byte write.
   logic [7:0]              ch_mode  [NUM_CHANNELS];  // Mode registers.
   logic [15:0]             ch_cmp   [NUM_CHANNELS];  // Compare values.
   logic [15:0]             ch_rld   [NUM_CHANNELS];  // Reload values.
   logic [7:0]              rd_mux;      // Combinational read selection.

   // Address of a channel's low value byte; high byte sits one above.
   function automatic logic [7:0] low_addr(input int idx);
      return ADDR_VALUE_LOW_BASE + 8'(idx) * ADDR_VALUE_STRIDE;
   endfunction : low_addr

   assign cfg_wr = sfr_wr && (sfr_addr == ADDR_PWM_CYCLE_CONFIG);

   // ****************************************************************
   // Configuration register
   // ****************************************************************

   // Software-owned fields. Bits 4 to 2 have no storage, so writes there
   // vanish and reads return zero.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reload_reg_select_reg    <= RST_PWM_CYCLE_CONFIG[POS_RELOAD_REG_SELECT];
         cycle_ovf_irq_enable_reg <= RST_PWM_CYCLE_CONFIG[POS_CYCLE_OVF_IRQ_EN];
         cycle_length_field_reg   <= cpc_len_t'(
            RST_PWM_CYCLE_CONFIG[POS_CYCLE_LEN_MSB:POS_CYCLE_LEN_LSB]);
      end else if (cfg_wr) begin
         reload_reg_select_reg    <= sfr_wdata[POS_RELOAD_REG_SELECT];
         cycle_ovf_irq_enable_reg <= sfr_wdata[POS_CYCLE_OVF_IRQ_EN];
         cycle_length_field_reg   <= cpc_len_t'(
            sfr_wdata[POS_CYCLE_LEN_MSB:POS_CYCLE_LEN_LSB]);
      end
   end

   // Sticky overflow flag. Hardware only ever sets it; software may write
   // either value. A hardware set in the same cycle as a software clear
   // wins, so no overflow is ever lost.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cycle_ovf_flag_reg <= RST_PWM_CYCLE_CONFIG[POS_CYCLE_OVF_FLAG];
      end else if (cycle_ovf) begin
         cycle_ovf_flag_reg <= 1'b1;
      end else if (cfg_wr) begin
         cycle_ovf_flag_reg <= sfr_wdata[POS_CYCLE_OVF_FLAG];
      end
   end

   assign counter_array_irq_req = cycle_ovf_flag_reg & cycle_ovf_irq_enable_reg;

   // ****************************************************************
   // Cycle overflow detection
   // ****************************************************************

   // Keep the previous count to see the selected bit field wrap.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         counter_prev_reg <= RST_CHANNEL_VALUE;
      end else begin
         counter_prev_reg <= array_main_counter;
      end
   end

   assign cycle_mask = cpc_len_mask(cycle_length_field_reg);

   // The field overflows when it goes from all ones to all zeros. A counter
   // that is loaded by software across that pattern also counts as a wrap;
   // that is accepted since the timebase owns its own load discipline.
   // overflow of chosen bit.
   assign cycle_ovf = ((counter_prev_reg & cycle_mask) == cycle_mask)
                   && ((array_main_counter & cycle_mask) == 16'h0000);

   assign cycle_ovf_pulse = cycle_ovf;

   // ****************************************************************
   // Channel address decode and instances
   // ****************************************************************

   // Decode per-channel write strobes from the bus address.
   always_comb begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         mode_wr[i] = sfr_wr && (sfr_addr == ADDR_MODE_BASE + 8'(i));
         low_wr[i]  = sfr_wr && (sfr_addr == low_addr(i));
         high_wr[i] = sfr_wr && (sfr_addr == low_addr(i) + 8'h01);
      end
   end

   // One slice per channel; all share the cycle length and overflow event.
   for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_ch
      cpc_channel u_channel (
         .clk             (clk),
         .rstn            (rstn),
         .mode_wr         (mode_wr[g]),
         .value_low_wr    (low_wr[g]),
         .value_high_wr   (high_wr[g]),
         .wdata           (sfr_wdata),
         .sel_reload      (reload_reg_select_reg),
         .cycle_len       (cycle_length_field_reg),
         .cycle_ovf       (cycle_ovf),
         .main_counter    (array_main_counter),
         .mode_reg        (ch_mode[g]),
         .compare_reg     (ch_cmp[g]),
         .reload_reg      (ch_rld[g]),
         .wide_pwm_select (wide_pwm_select[g]),
         .pwm_out         (pwm_out[g])
      );
      assign channel_compare_value[g*16 +: 16] = ch_cmp[g];
   end

   // ****************************************************************
   // Read-back path
   // ****************************************************************

   // Select the byte to return. Unmapped addresses read zero.
   always_comb begin
      rd_mux = RST_READ_DATA;
      if (sfr_addr == ADDR_PWM_CYCLE_CONFIG) begin
         rd_mux = RST_READ_DATA;
         rd_mux[POS_RELOAD_REG_SELECT] = reload_reg_select_reg;
         rd_mux[POS_CYCLE_OVF_IRQ_EN]  = cycle_ovf_irq_enable_reg;
         rd_mux[POS_CYCLE_OVF_FLAG]    = cycle_ovf_flag_reg;
         rd_mux[POS_CYCLE_LEN_MSB:POS_CYCLE_LEN_LSB] = cycle_length_field_reg;
      end
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         if (sfr_addr == ADDR_MODE_BASE + 8'(i)) begin
            rd_mux = ch_mode[i];
         end
         if (sfr_addr == low_addr(i)) begin
            rd_mux = reload_reg_select_reg ? ch_rld[i][7:0] : ch_cmp[i][7:0];
         end
         if (sfr_addr == low_addr(i) + 8'h01) begin
            rd_mux = reload_reg_select_reg ? ch_rld[i][15:8] : ch_cmp[i][15:8];
         end
      end
   end

   // Registered read data: returned the cycle after the read strobe and
   // held until the next read, so the core can sample it at leisure.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sfr_rdata       <= RST_READ_DATA;
         sfr_rdata_valid <= 1'b0;
      end else begin
         sfr_rdata_valid <= sfr_rd;
         if (sfr_rd) begin
            sfr_rdata <= rd_mux;
         end
      end
   end

endmodule : cpc_top

// [tb/cpc_top_props.sv]
// Checker for the cycle configuration slice, watching the top ports only.
// Assumes the bench holds sfr_wr and sfr_rd low while rstn is low.
`timescale 1ns/1ps

module cpc_top_props
   import cpc_pkg::*;
#(
   parameter int NUM_CHANNELS = 3  // Channels served by the design.
)
(
   input wire logic                  clk,
   input wire logic                  rstn,
   input wire logic [7:0]            sfr_addr,
   input wire logic                  sfr_wr,
   input wire logic                  sfr_rd,
   input wire logic [7:0]            sfr_wdata,
   input wire logic [7:0]            sfr_rdata,
   input wire logic                  sfr_rdata_valid,
   input wire logic [15:0]           array_main_counter,
   input wire logic                  counter_array_irq_req,
   input wire logic                  cycle_ovf_pulse,
   input wire logic [NUM_CHANNELS-1:0]    wide_pwm_select,
   input wire logic [NUM_CHANNELS-1:0]    pwm_out,
   input wire logic [NUM_CHANNELS*16-1:0] channel_compare_value
);
   // ****************************************************************
   // Shadow state rebuilt from bus traffic
   // ****************************************************************
   logic [7:0]  cfg_sh;   // Last byte written to the cycle configuration.
   logic        flag_sh;  // Expected sticky overflow flag.
   logic [15:0] prev_sh;  // Counter value of the previous cycle.
   logic [15:0] mask_sh;  // Field mask for the selected cycle length.
   logic        cfg_wr;   // Write to the cycle configuration this cycle.
   logic        low_wr;   // Write to the low value byte of channel 0.

   assign cfg_wr  = sfr_wr && (sfr_addr == ADDR_PWM_CYCLE_CONFIG);
   assign low_wr  = sfr_wr && (sfr_addr == ADDR_VALUE_LOW_BASE);
   assign mask_sh = (16'h0100 << cfg_sh[1:0]) - 16'h0001;

   // Configuration shadow; bits 4 to 2 are kept but never compared.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cfg_sh <= 8'h00;
      end else if (cfg_wr) begin
         cfg_sh <= sfr_wdata;
      end
   end

   // Flag shadow: a hardware set wins over a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         flag_sh <= 1'b0;
      end else if (cycle_ovf_pulse) begin
         flag_sh <= 1'b1;
      end else if (cfg_wr) begin
         flag_sh <= sfr_wdata[5];
      end
   end

   // Previous counter value, cleared with reset like the design's copy.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         prev_sh <= 16'h0000;
      end else begin
         prev_sh <= array_main_counter;
      end
   end

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_read_valid_timing: assert property (sfr_rd |=> sfr_rdata_valid)
      else $error("read answer missing one cycle after the strobe");
   a_valid_needs_read: assert property (sfr_rdata_valid |-> $past(sfr_rd))
      else $error("read valid without a read strobe");
   a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data changed without a read");
   a_cfg_readback: assert property (sfr_rd && sfr_addr == ADDR_PWM_CYCLE_CONFIG |=>
      sfr_rdata == {$past(cfg_sh[7:6]), $past(flag_sh), 3'b000, $past(cfg_sh[1:0])})
      else $error("configuration read back wrong");
   a_irq_from_flag: assert property (counter_array_irq_req == (flag_sh && cfg_sh[6]))
      else $error("interrupt request does not match flag and enable");
   a_ovf_detect: assert property (cycle_ovf_pulse == (((prev_sh & mask_sh) == mask_sh)
      && ((array_main_counter & mask_sh) == 16'h0000)))
      else $error("overflow pulse does not match selected field wrap");
   a_steer_compare: assert property (low_wr && !cfg_sh[7] |=>
      channel_compare_value[7:0] == $past(sfr_wdata))
      else $error("compare byte not written");
   a_steer_reload: assert property (low_wr && cfg_sh[7] && !cycle_ovf_pulse |=>
      $stable(channel_compare_value[7:0]))
      else $error("reload write disturbed compare byte");
   a_wide_select: assert property (sfr_wr && sfr_addr == ADDR_MODE_BASE |=>
      wide_pwm_select[0] == $past(sfr_wdata[7]))
      else $error("wide select does not follow mode bit 7");

   c_ovf_enabled: cover property (cycle_ovf_pulse && cfg_sh[6]);
   c_cfg_read: cover property (sfr_rd && sfr_addr == ADDR_PWM_CYCLE_CONFIG);
   c_reload_write: cover property (low_wr && cfg_sh[7]);
endmodule : cpc_top_props

bind cpc_top cpc_top_props #(.NUM_CHANNELS(NUM_CHANNELS)) u_props (
   .clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid),
   .array_main_counter(array_main_counter), .counter_array_irq_req(counter_array_irq_req),
   .cycle_ovf_pulse(cycle_ovf_pulse), .wide_pwm_select(wide_pwm_select),
   .pwm_out(pwm_out), .channel_compare_value(channel_compare_value));

// [tb/cpc_top_tb.sv]
// Self-checking bench for the cycle configuration slice.
// Assumes the bench itself plays the bus master and the counter timebase.
`timescale 1ns/1ps

module cpc_top_tb;
   import cpc_pkg::*;
   logic        clk = 1'b0;          // 200 MHz system clock.
   logic        rstn = 1'b0;         // Synchronous reset, active low.
   logic [7:0]  sfr_addr = 8'h00;    // Register address.
   logic        sfr_wr = 1'b0;       // Write strobe.
   logic        sfr_rd = 1'b0;       // Read strobe.
   logic [7:0]  sfr_wdata = 8'h00;   // Write data.
   logic [15:0] cnt = 16'h0000;      // Main counter driven by the bench.
   logic [7:0]  sfr_rdata;           // Read data.
   logic        sfr_rdata_valid;     // Read answer strobe.
   logic        irq;                 // Shared interrupt request.
   logic        ovf;                 // Cycle overflow pulse.
   logic [2:0]  wide;                // Wide PWM selects.
   logic [2:0]  pwm;                 // PWM outputs.
   logic [47:0] cmp;                 // Compare values of all channels.
   int          failures = 0;        // Mismatches seen.
   int          num_checks = 0;      // Comparisons made.
   int          cycles = 0;          // Cycle count for the hang guard.

   always #2.5 clk = ~clk;

   cpc_top #(.NUM_CHANNELS(3)) dut (
      .clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid),
      .array_main_counter(cnt), .counter_array_irq_req(irq), .cycle_ovf_pulse(ovf),
      .wide_pwm_select(wide), .pwm_out(pwm), .channel_compare_value(cmp));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One write; the request is taken at the second edge. The short wait
   // at the end lets the registers settle, so a check right after sees them.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
      #1;
   endtask : wr

   // One read; the answer stands for the cycle after the taking edge.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1;
      chk("read valid", 16'h0001, {15'h0000, sfr_rdata_valid});
      chk(what, {8'h00, exp}, {8'h00, sfr_rdata});
   endtask : rd

   // Moves the counter across a boundary and checks the pulse there.
   task automatic step(input logic [15:0] a, input logic [15:0] b, input logic exp);
      @(posedge clk);
      cnt <= a;
      @(posedge clk);
      cnt <= b;
      #1;
      chk("overflow pulse", {15'h0000, exp}, {15'h0000, ovf});
   endtask : step

   // Sets the counter and checks the registered PWM outputs.
   task automatic pwm_at(input logic [15:0] v, input logic [2:0] exp);
      @(posedge clk);
      cnt <= v;
      @(posedge clk);
      @(posedge clk);
      #1;
      chk("pwm outputs", {13'h0000, exp}, {13'h0000, pwm});
   endtask : pwm_at

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      rd(ADDR_PWM_CYCLE_CONFIG, 8'h00, "config reset");
      rd(ADDR_MODE_BASE, 8'h00, "mode reset");
      chk("irq after reset", 16'h0000, {15'h0000, irq});
      $display("test reset done");
   endtask : t_reset

   // Each length code wraps only its own field; the flag stays masked.
   task automatic t_lengths;
      logic [15:0] m;
      for (int i = 0; i < 4; i++) begin
         m = (16'h0100 << i) - 16'h0001;
         wr(ADDR_PWM_CYCLE_CONFIG, 8'(i));
         step(m >> 1, (m >> 1) + 16'h0001, 1'b0);
         step(m, m + 16'h0001, 1'b1);
         rd(ADDR_PWM_CYCLE_CONFIG, 8'h20 | 8'(i), "flag and length");
         chk("irq masked", 16'h0000, {15'h0000, irq});
      end
      $display("test lengths done");
   endtask : t_lengths

   // Sticky flag, software set, masking and unused bits.
   task automatic t_irq;
      wr(ADDR_PWM_CYCLE_CONFIG, 8'h41);
      step(16'h01FF, 16'h0200, 1'b1);
      step(16'h0210, 16'h0220, 1'b0);
      chk("irq raised", 16'h0001, {15'h0000, irq});
      rd(ADDR_PWM_CYCLE_CONFIG, 8'h61, "sticky flag");
      wr(ADDR_PWM_CYCLE_CONFIG, 8'h21);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      wr(ADDR_PWM_CYCLE_CONFIG, 8'h41);
      chk("irq after clear", 16'h0000, {15'h0000, irq});
      wr(ADDR_PWM_CYCLE_CONFIG, 8'hFF);
      rd(ADDR_PWM_CYCLE_CONFIG, 8'hE3, "unused bits");
      chk("irq from software set", 16'h0001, {15'h0000, irq});
      wr(ADDR_PWM_CYCLE_CONFIG, 8'h00);
      wr(8'h80, 8'hAA);
      rd(8'h80, 8'h00, "unmapped read");
      $display("test irq done");
   endtask : t_irq

   // Value addresses steered between compare and reload.
   task automatic t_steer;
      wr(8'hE9, 8'h34);
      wr(8'hEA, 8'h12);
      wr(8'hED, 8'h00);
      wr(8'hEE, 8'h01);
      chk("compare 0", 16'h1234, cmp[15:0]);
      wr(ADDR_PWM_CYCLE_CONFIG, 8'h80);
      wr(8'hE9, 8'h78);
      wr(8'hEA, 8'h56);
      wr(8'hEB, 8'h55);
      wr(8'hED, 8'h66);
      chk("compare kept", 16'h1234, cmp[15:0]);
      rd(8'hEA, 8'h56, "reload high");
      wr(ADDR_PWM_CYCLE_CONFIG, 8'h00);
      rd(8'hE9, 8'h34, "compare low");
      $display("test steer done");
   endtask : t_steer

   // Reload copy, mode exclusions and live cycle length on the outputs.
   task automatic t_reload;
      wr(ADDR_MODE_BASE, 8'h42);
      wr(8'hDB, 8'h00);
      wr(8'hDC, 8'hC2);
      chk("wide selects", 16'h0004, {13'h0000, wide});
      wr(ADDR_PWM_CYCLE_CONFIG, 8'h01);
      step(16'h01FF, 16'h0200, 1'b1);
      @(posedge clk);
      #1;
      chk("compare 0 reloaded", 16'h5678, cmp[15:0]);
      chk("compare 1 idle", 16'h0000, cmp[31:16]);
      chk("compare 2 wide", 16'h0100, cmp[47:32]);
      pwm_at(16'h0270, 3'b001);
      pwm_at(16'h0080, 3'b100);
      pwm_at(16'h0170, 3'b000);
      wr(ADDR_PWM_CYCLE_CONFIG, 8'h00);
      @(posedge clk);
      #1;
      chk("pwm after length change", 16'h0001, {13'h0000, pwm});
      $display("test reload done");
   endtask : t_reload

   // ****************************************************************
   // Closing and main sequence
   // ****************************************************************
   task automatic report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   // Hang guard, far above the roughly 110 cycles the tests need.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         report_and_stop();
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_lengths();
      t_irq();
      t_steer();
      t_reload();
      report_and_stop();
   end
endmodule : cpc_top_tb
